//--- qps_pkg.sv
/*
  Shared constants, encodings and carrier types for the four-pin
  multipurpose port with address-decoded chip-select strobes.
  Assumes a byte-wide special-function register port from the core
  and a 16-bit external data bus with active-low read/write strobes.
*/
package qps_pkg;

  ////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [7:0] SFR_LATCH = 8'hD8;
  localparam logic [7:0] SFR_CFG_LO = 8'hC2;
  localparam logic [7:0] SFR_CFG_HI = 8'hC3;
  // Pin x base high byte at SFR_BASE_FIRST + 2x, low byte one above
  localparam logic [7:0] SFR_BASE_FIRST = 8'hE8;
  localparam logic [7:0] SFR_INVERT = 8'hF8;

  ////////////////////////////////////////////////////////////////////
  // Widths, field positions, reset values
  localparam int NUM_PINS = 4;
  localparam int CFG_FIELD_W = 4;
  localparam int FUN_POS = 2;
  localparam int CMP_POS = 0;
  localparam int IRQ_THREE_PIN = 2;
  localparam int IRQ_TWO_PIN = 3;
  localparam logic [3:0] LATCH_RST = 4'hF;
  localparam logic [3:0] INVERT_RST = 4'h0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [3:0] PINS_HIGH = 4'hF;

  ////////////////////////////////////////////////////////////////////
  // Function field and compare-length encodings
  typedef enum logic [1:0] {
    MODE_IO = 2'b00,
    MODE_RD = 2'b01,
    MODE_WR = 2'b10,
    MODE_RW = 2'b11
  } qps_mode_t;

  localparam logic [1:0] CMP_FULL = 2'b00;
  localparam logic [1:0] CMP_A1 = 2'b01;
  localparam logic [1:0] CMP_A2 = 2'b10;
  localparam logic [1:0] CMP_HIGH = 2'b11;
  localparam logic [15:0] MASK_FULL = 16'hFFFF;
  localparam logic [15:0] MASK_A1 = 16'hFFFE;
  localparam logic [15:0] MASK_A2 = 16'hFFFC;
  localparam logic [15:0] MASK_HIGH = 16'hFF00;

  ////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic [7:0] wrData;
  } qps_sfr_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rdN;
    logic wrN;
  } qps_xbus_t;

  typedef struct packed {
    logic [3:0] latch;
    logic [7:0] cfgLo;
    logic [7:0] cfgHi;
    logic [3:0][15:0] base;
    logic [3:0] invert;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
    logic irqTwoN;
    logic irqThreeN;
    logic [7:0] rdData;
  } qps_state_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] stable;
  } qps_sync_t;

  // Four-bit config nibble of one pin out of {cfgHi, cfgLo}
  function automatic logic [3:0] pinCfg(input logic [15:0] cfg,
                                        input int pin);
    return cfg[pin*CFG_FIELD_W +: CFG_FIELD_W];
  endfunction

endpackage

//--- qps_sync.sv
/*
  Three-stage synchroniser for the four port pins.
  Assumes pins change asynchronously to clk; a new level is accepted
  once the second and third stages agree.
*/
`timescale 1ns/1ps
module qps_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins and filtered level
  input wire logic [3:0] pinIn,
  output logic [3:0] pinLevel
);

  qps_pkg::qps_sync_t st_q;
  qps_pkg::qps_sync_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < qps_pkg::NUM_PINS; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.stable[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= {4{qps_pkg::PINS_HIGH}};
    end else begin
      st_q <= st_d;
    end
  end

  assign pinLevel = st_q.stable;

endmodule // qps_sync

//--- qps_decode.sv
/*
  Address decoder for the four chip-select strobes.
  Assumes the external bus fields are on clk and stable while a strobe
  is low; output is combinational and registered by the caller.
*/
`timescale 1ns/1ps
module qps_decode (
  // External data bus
  input qps_pkg::qps_xbus_t xbus,
  // Configuration
  input wire logic [15:0] cfg,
  input wire logic [3:0][15:0] base,
  // Strobe active per pin
  output logic [3:0] hit
);

  function automatic logic addrMatch(input logic [15:0] addr,
                                     input logic [15:0] baseAddr,
                                     input logic [1:0] cmp);
    logic [15:0] mask;
    unique case (cmp)
      qps_pkg::CMP_FULL: mask = qps_pkg::MASK_FULL;
      qps_pkg::CMP_A1: mask = qps_pkg::MASK_A1;
      qps_pkg::CMP_A2: mask = qps_pkg::MASK_A2;
      qps_pkg::CMP_HIGH: mask = qps_pkg::MASK_HIGH;
    endcase
    return ((addr ^ baseAddr) & mask) == 16'h0000;
  endfunction

  always_comb begin
    logic [3:0] c;
    logic m;
    c = 4'h0;
    m = 1'b0;
    hit = 4'h0;
    for (int i = 0; i < qps_pkg::NUM_PINS; i++) begin
      c = qps_pkg::pinCfg(cfg, i);
      m = addrMatch(xbus.addr, base[i], c[1:0]);
      unique case (c[3:2])
        qps_pkg::MODE_IO: hit[i] = 1'b0;
        qps_pkg::MODE_RD: hit[i] = m & ~xbus.rdN;
        // pointer writes in range pulse too
        qps_pkg::MODE_WR: hit[i] = m & ~xbus.wrN;
        qps_pkg::MODE_RW: hit[i] = m & ~(xbus.rdN & xbus.wrN);
      endcase
    end
  end

endmodule // qps_decode

//--- qps_port.sv
/*
  Four-pin multipurpose port: quasi-bidirectional I/O or decoded
  chip-select strobes following the external data read/write strobes.
  Assumes a same-clock SFR port from the core (write taken on the edge,
  read data one cycle later) and same-clock external bus strobes.
*/
//
// Contract
// - Four-bit port at SFR D8h bits 3..0, each pin configured alone.
// - Mode 0 pin is a quasi-bidirectional I/O bit.
// - In I/O mode pins 2 and 3 feed interrupts three and two.
// - Mode 1 pin strobes with external read at matching address.
// - Mode 2 pin strobes with external write at matching address.
// - Mode 3 pin strobes with read or write at matching address.
// - Each pin has a 16-bit base in high and low byte registers.
// - Two shared control registers hold mode and compare length.
// - Strobes are active low unless the pin's invert bit is 1.
// - Data-pointer write in range pulses a write-strobe pin.
// - Port writes drive only I/O-mode pins; strobe pins keep strobing.
// - Compare length: 00 all, 01 A15-A1, 10 A15-A2, 11 A15-A8.
// - Function field: 00 I/O, 01 read, 10 write, 11 either.
`timescale 1ns/1ps
module qps_port (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Special-function register port
  input qps_pkg::qps_sfr_req_t sfrReq,
  output logic [7:0] sfrRdData,
  // External data bus from the core
  input qps_pkg::qps_xbus_t xbus,
  // Interrupt enables and pin-fed interrupt levels
  input wire logic irqTwoEn,
  input wire logic irqThreeEn,
  output logic extIrqTwoN,
  output logic extIrqThreeN,
  // Port pins
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe
);

  localparam qps_pkg::qps_state_t ST_RST = '{
    latch: qps_pkg::LATCH_RST,
    cfgLo: qps_pkg::CFG_RST,
    cfgHi: qps_pkg::CFG_RST,
    base: {4{qps_pkg::BASE_RST}},
    invert: qps_pkg::INVERT_RST,
    pinOut: qps_pkg::PINS_HIGH,
    pinOe: 4'h0,
    irqTwoN: 1'b1,
    irqThreeN: 1'b1,
    rdData: 8'h00
  };

  qps_pkg::qps_state_t st_q;
  qps_pkg::qps_state_t st_d;
  logic [3:0] pinLevel;
  logic [3:0] hit;
  logic [15:0] cfgAll;

  function automatic logic [7:0] baseHiAddr(input int pin);
    return qps_pkg::SFR_BASE_FIRST + 8'(2 * pin);
  endfunction

  assign cfgAll = {st_q.cfgHi, st_q.cfgLo};

  ////////////////////////////////////////////////////////////////////
  // Helpers

  qps_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(pinIn),
    .pinLevel(pinLevel)
  );

  qps_decode u_decode (
    .xbus(xbus),
    .cfg(cfgAll),
    .base(st_q.base),
    .hit(hit)
  );

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [3:0] c;
    st_d = st_q;
    c = 4'h0;
    // Register writes
    if (sfrReq.wrEn) begin
      if (sfrReq.addr == qps_pkg::SFR_LATCH) begin
        st_d.latch = sfrReq.wrData[3:0];
      end
      if (sfrReq.addr == qps_pkg::SFR_CFG_LO) begin
        st_d.cfgLo = sfrReq.wrData;
      end
      if (sfrReq.addr == qps_pkg::SFR_CFG_HI) begin
        st_d.cfgHi = sfrReq.wrData;
      end
      if (sfrReq.addr == qps_pkg::SFR_INVERT) begin
        st_d.invert = sfrReq.wrData[3:0];
      end
      for (int i = 0; i < qps_pkg::NUM_PINS; i++) begin
        if (sfrReq.addr == baseHiAddr(i)) begin
          st_d.base[i][15:8] = sfrReq.wrData;
        end
        if (sfrReq.addr == baseHiAddr(i) + 8'h01) begin
          st_d.base[i][7:0] = sfrReq.wrData;
        end
      end
    end
    // Register reads; the port reads pin levels, unused bits are zero
    if (sfrReq.rdEn) begin
      st_d.rdData = 8'h00;
      if (sfrReq.addr == qps_pkg::SFR_LATCH) begin
        st_d.rdData = {4'h0, pinLevel};
      end
      if (sfrReq.addr == qps_pkg::SFR_CFG_LO) begin
        st_d.rdData = st_q.cfgLo;
      end
      if (sfrReq.addr == qps_pkg::SFR_CFG_HI) begin
        st_d.rdData = st_q.cfgHi;
      end
      if (sfrReq.addr == qps_pkg::SFR_INVERT) begin
        st_d.rdData = {4'h0, st_q.invert};
      end
      for (int i = 0; i < qps_pkg::NUM_PINS; i++) begin
        if (sfrReq.addr == baseHiAddr(i)) begin
          st_d.rdData = st_q.base[i][15:8];
        end
        if (sfrReq.addr == baseHiAddr(i) + 8'h01) begin
          st_d.rdData = st_q.base[i][7:0];
        end
      end
    end
    // Pin drivers
    for (int i = 0; i < qps_pkg::NUM_PINS; i++) begin
      c = qps_pkg::pinCfg(cfgAll, i);
      if (c[3:2] == qps_pkg::MODE_IO) begin
        // quasi-bidirectional: drive low, release for high
        st_d.pinOut[i] = st_q.latch[i];
        st_d.pinOe[i] = ~st_q.latch[i];
      end else begin
        st_d.pinOut[i] = st_q.invert[i] ? hit[i] : ~hit[i];
        st_d.pinOe[i] = 1'b1;
      end
    end
    // pins 2 and 3 feed the external interrupts
    c = qps_pkg::pinCfg(cfgAll, qps_pkg::IRQ_THREE_PIN);
    st_d.irqThreeN = (c[3:2] == qps_pkg::MODE_IO && irqThreeEn) ?
                     pinLevel[qps_pkg::IRQ_THREE_PIN] : 1'b1;
    c = qps_pkg::pinCfg(cfgAll, qps_pkg::IRQ_TWO_PIN);
    st_d.irqTwoN = (c[3:2] == qps_pkg::MODE_IO && irqTwoEn) ?
                   pinLevel[qps_pkg::IRQ_TWO_PIN] : 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfrRdData = st_q.rdData;
  assign pinOut = st_q.pinOut;
  assign pinOe = st_q.pinOe;
  assign extIrqTwoN = st_q.irqTwoN;
  assign extIrqThreeN = st_q.irqThreeN;

  ////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] cfgP0;
  logic [3:0] cfgP2;
  logic [3:0] cfgP3;
  assign cfgP0 = qps_pkg::pinCfg(cfgAll, 0);
  assign cfgP2 = qps_pkg::pinCfg(cfgAll, qps_pkg::IRQ_THREE_PIN);
  assign cfgP3 = qps_pkg::pinCfg(cfgAll, qps_pkg::IRQ_TWO_PIN);

  a_latch_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    sfrReq.wrEn && sfrReq.addr == qps_pkg::SFR_LATCH
    |=> st_q.latch == $past(sfrReq.wrData[3:0]))
    else $error("port latch did not take written value");

  a_io_drive: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0[3:2] == qps_pkg::MODE_IO
    |=> pinOe[0] == ~$past(st_q.latch[0]) &&
        pinOut[0] == $past(st_q.latch[0]))
    else $error("I/O pin drive does not follow latch");

  a_irq_three: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP2[3:2] == qps_pkg::MODE_IO && irqThreeEn
    |=> extIrqThreeN == $past(pinLevel[qps_pkg::IRQ_THREE_PIN]))
    else $error("interrupt three does not follow pin 2");

  a_rd_strobe: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0[3:2] == qps_pkg::MODE_RD && xbus.rdN
    |=> pinOut[0] == ~$past(st_q.invert[0]) && pinOe[0])
    else $error("read strobe active without read");

  a_wr_pulse: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0 == {qps_pkg::MODE_WR, qps_pkg::CMP_FULL} &&
    xbus.addr == st_q.base[0] && !xbus.wrN
    |=> pinOut[0] == $past(st_q.invert[0]))
    else $error("write strobe missing on matching write");

  a_rw_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0[3:2] == qps_pkg::MODE_RW && xbus.rdN && xbus.wrN
    |=> pinOut[0] == ~$past(st_q.invert[0]))
    else $error("read/write strobe active while bus idle");

  a_cfg_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    sfrReq.wrEn && sfrReq.addr == qps_pkg::SFR_CFG_HI
    |=> st_q.cfgHi == $past(sfrReq.wrData))
    else $error("control register write lost");

  a_base_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    sfrReq.wrEn && sfrReq.addr == qps_pkg::SFR_BASE_FIRST
    |=> st_q.base[0][15:8] == $past(sfrReq.wrData))
    else $error("base high byte write lost");

  a_strobe_keep: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0[3:2] != qps_pkg::MODE_IO ##1
    cfgP0[3:2] != qps_pkg::MODE_IO |-> pinOe[0])
    else $error("strobe pin released by port write");

  a_high_cmp: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0 == {qps_pkg::MODE_RD, qps_pkg::CMP_HIGH} &&
    xbus.addr[15:8] == st_q.base[0][15:8] && !xbus.rdN
    |=> pinOut[0] == $past(st_q.invert[0]))
    else $error("high-byte compare failed to match");

  a_wr_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0[3:2] == qps_pkg::MODE_WR && xbus.wrN
    |=> pinOut[0] == ~$past(st_q.invert[0]) && pinOe[0])
    else $error("write strobe active without write");

  a_rd_match: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0 == {qps_pkg::MODE_RD, qps_pkg::CMP_FULL} &&
    xbus.addr == st_q.base[0] && !xbus.rdN
    |=> pinOut[0] == $past(st_q.invert[0]))
    else $error("read strobe missing on matching read");

  a_rw_match: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0 == {qps_pkg::MODE_RW, qps_pkg::CMP_FULL} &&
    xbus.addr == st_q.base[0] && !(xbus.rdN && xbus.wrN)
    |=> pinOut[0] == $past(st_q.invert[0]))
    else $error("read/write strobe missing on matching access");

  a_lsb_mask: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0 == {qps_pkg::MODE_WR, qps_pkg::CMP_A1} &&
    xbus.addr[15:1] == st_q.base[0][15:1] && !xbus.wrN
    |=> pinOut[0] == $past(st_q.invert[0]))
    else $error("bit-zero-masked compare failed to match");

  a_range_miss: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP0 == {qps_pkg::MODE_WR, qps_pkg::CMP_A2} &&
    xbus.addr[15:2] != st_q.base[0][15:2]
    |=> pinOut[0] == ~$past(st_q.invert[0]))
    else $error("strobe active outside its address range");

  a_irq_gate: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP2[3:2] != qps_pkg::MODE_IO || !irqThreeEn
    |=> extIrqThreeN)
    else $error("interrupt three fed while pin 2 not in I/O mode");

  a_irq_two: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfgP3[3:2] == qps_pkg::MODE_IO && irqTwoEn
    |=> extIrqTwoN == $past(pinLevel[qps_pkg::IRQ_TWO_PIN]))
    else $error("interrupt two does not follow pin 3");

  a_port_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    sfrReq.rdEn && sfrReq.addr == qps_pkg::SFR_LATCH
    |=> sfrRdData == {4'h0, $past(pinLevel)})
    else $error("port read does not return pin levels");

  a_invert_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    sfrReq.wrEn && sfrReq.addr == qps_pkg::SFR_INVERT
    |=> st_q.invert == $past(sfrReq.wrData[3:0]))
    else $error("polarity register write lost");

endmodule // qps_port

//--- qps_periph_model.sv
/*
  Peripheral model on the four port pins: pull-ups, optional external
  pull-down on released pins, and a counter of select pulses on pin 0.
  Assumes released pins float high and strobe pins are always driven.
*/
`timescale 1ns/1ps
module qps_periph_model (
  // Clock
  input wire logic clk,
  // Pins from the port
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  // Peripheral side
  input wire logic [3:0] extLow,
  input wire logic selLevel,
  output logic [3:0] pinIn,
  output int selCount
);
  logic selPrev;
  initial begin
    selCount = 0;
    selPrev = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // quasi-bidirectional pull-up
  assign pinIn = (pinOe & pinOut) | (~pinOe & ~extLow);
  always @(posedge clk) begin
    if (pinOe[0] && pinOut[0] == selLevel && !selPrev) begin
      selCount <= selCount + 1;
    end
    selPrev <= pinOe[0] && pinOut[0] == selLevel;
  end
endmodule // qps_periph_model

//--- qps_port_bench.sv
/*
  Self-checking bench for the four-pin strobe port.
  Assumes qps_pkg and qps_periph_model are compiled first.
*/
`timescale 1ns/1ps
module qps_port_bench;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  qps_pkg::qps_sfr_req_t sfrReq = '0;
  qps_pkg::qps_xbus_t xbus = '{16'h0000, 1'b1, 1'b1};
  logic [7:0] sfrRdData;
  logic irqTwoEn = 1'b0;
  logic irqThreeEn = 1'b0;
  logic extIrqTwoN, extIrqThreeN;
  logic [3:0] pinIn, pinOut, pinOe, lvl, inv, lat;
  logic [3:0] extLow = 4'h0;
  logic [15:0] a;
  logic [15:0] flips[6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004,
                            16'h0100, 16'h8000};
  logic [15:0] maskTab[4] = '{16'hFFFF, 16'hFFFE, 16'hFFFC, 16'hFF00};
  int md[4], cm[4], bs[4];
  int selCount, kind, n;
  int errors = 0;
  int checkCount = 0;

  always #4 clk = ~clk;

  qps_port i_dut (.clk(clk), .sys_rst(sysRst), .sfrReq(sfrReq),
    .sfrRdData(sfrRdData), .xbus(xbus), .irqTwoEn(irqTwoEn),
    .irqThreeEn(irqThreeEn), .extIrqTwoN(extIrqTwoN),
    .extIrqThreeN(extIrqThreeN), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe));
  qps_periph_model i_periph (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .extLow(extLow), .selLevel(1'b1), .pinIn(pinIn),
    .selCount(selCount));

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic completeRun;
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic sfrWr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk);
    sfrReq = '{ad, 1'b1, 1'b0, d};
    @(negedge clk);
    sfrReq.wrEn = 1'b0;
  endtask

  task automatic sfrRdChk(input logic [7:0] ad, input logic [7:0] e);
    @(negedge clk);
    sfrReq = '{ad, 1'b0, 1'b1, 8'h00};
    @(negedge clk);
    sfrReq.rdEn = 1'b0;
    check("sfr read", sfrRdData, e);
  endtask

  // Reference: pins as they should stand after the last bus edge
  function automatic logic [7:0] expPins();
    logic [7:0] e;
    logic hit;
    for (int p = 0; p < 4; p++) begin
      hit = ((xbus.addr ^ 16'(bs[p])) & maskTab[cm[p]]) == 16'h0000 &&
            ((md[p][0] && !xbus.rdN) || (md[p][1] && !xbus.wrN));
      e[p] = md[p] == 0 ? lat[p] : hit ~^ inv[p];
      e[p + 4] = md[p] == 0 ? ~lat[p] : 1'b1;
    end
    return e;
  endfunction

  task automatic setup(input logic [3:0] invV, input logic [3:0] latV);
    logic [7:0] c[2];
    for (int p = 0; p < 4; p++) begin
      c[p / 2][(p % 2) * 4 +: 4] = {md[p][1:0], cm[p][1:0]};
      sfrWr(qps_pkg::SFR_BASE_FIRST + 8'(2 * p), 8'(bs[p] >> 8));
      sfrWr(qps_pkg::SFR_BASE_FIRST + 8'(2 * p + 1), 8'(bs[p]));
    end
    sfrWr(qps_pkg::SFR_CFG_LO, c[0]);
    sfrWr(qps_pkg::SFR_CFG_HI, c[1]);
    sfrWr(qps_pkg::SFR_INVERT, {4'h0, invV});
    sfrWr(qps_pkg::SFR_LATCH, {4'h0, latV});
    inv = invV;
    lat = latV;
  endtask

  // Compares the previous access, then presents the next one
  task automatic xAcc(input logic [15:0] ad, input logic r,
                      input logic w);
    @(negedge clk);
    check("pins", {pinOe, pinOut}, expPins());
    xbus = '{ad, ~r, ~w};
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(51804));
    repeat (12) @(posedge clk);
    @(negedge clk);
    sysRst = 1'b0;
    @(negedge clk);
    check("reset pins", {pinOe, pinOut}, 8'h0F);
    check("reset irq", {extIrqTwoN, extIrqThreeN}, 2'b11);
    repeat (4) @(negedge clk);
    sfrRdChk(qps_pkg::SFR_LATCH, 8'h0F);
    sfrWr(8'h55, 8'hA0);
    sfrRdChk(8'h55, 8'h00);
    check("unmapped write", {pinOe, pinOut}, 8'h0F);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      lat = 4'($urandom);
      extLow = 4'($urandom) & lat;
      lvl = lat & ~extLow;
      {irqTwoEn, irqThreeEn} = 2'($urandom);
      sfrWr(qps_pkg::SFR_LATCH, {4'h0, lat});
      // Sync takes up to 4 edges, interrupt one more
      repeat (6) @(negedge clk);
      check("io pins", {pinOe, pinOut}, expPins());
      check("irq", {extIrqTwoN, extIrqThreeN},
            {~irqTwoEn | lvl[3], ~irqThreeEn | lvl[2]});
      sfrRdChk(qps_pkg::SFR_LATCH, {4'h0, lvl});
    end
    extLow = 4'h0;
    $display("test io done");
    for (int m = 0; m < 16; m++) begin
      for (int p = 0; p < 4; p++) begin
        md[p] = (m + p) % 4;
        cm[p] = (m / 4 + p) % 4;
        bs[p] = $urandom % 65536;
      end
      setup(4'($urandom), 4'($urandom));
      for (int k = 0; k < 16; k++) begin
        a = 16'(bs[$urandom % 4]) ^ flips[$urandom % 6];
        kind = $urandom % 3;
        xAcc(a, kind == 1, kind == 2);
        if (k == 8) begin
          lat = 4'($urandom);
          sfrWr(qps_pkg::SFR_LATCH, {4'h0, lat});
        end
      end
      // Exact hits on pin 0's base, so each compare length of pin 0 sees a match
      xAcc(16'(bs[0]), 1'b1, 1'b0);
      xAcc(16'(bs[0]), 1'b0, 1'b1);
      xAcc(16'h0000, 1'b0, 1'b0);
    end
    $display("test strobe done");
    md = '{2, 0, 0, 0};
    cm = '{2, 0, 0, 0};
    bs[0] = 16'h1234;
    setup(4'h1, 4'hF);
    n = selCount;
    for (int w = 16'h1232; w < 16'h1239; w++) begin
      xAcc(16'(w), 1'b0, 1'b1);
      xAcc(16'(w), 1'b0, 1'b0);
    end
    xAcc(16'h0000, 1'b0, 1'b0);
    check("pulse count", 16'(selCount - n), 16'h0004);
    $display("test pulse done");
    // Reset in mid-run must restore every default
    @(negedge clk);
    sysRst = 1'b1;
    repeat (2) @(negedge clk);
    sysRst = 1'b0;
    @(negedge clk);
    check("rerun pins", {pinOe, pinOut}, 8'h0F);
    check("rerun read", sfrRdData, 8'h00);
    sfrRdChk(qps_pkg::SFR_CFG_HI, 8'h00);
    sfrRdChk(qps_pkg::SFR_INVERT, 8'h00);
    sfrRdChk(qps_pkg::SFR_BASE_FIRST + 8'h01, 8'h00);
    $display("test rerun done");
    completeRun();
  end

  // Tests need about 900 cycles; over twenty times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    completeRun();
  end
endmodule // qps_port_bench
